/* File: core/cbce_engine.sv */
// Purpose: command engine moving the device configuration as a checked block
// Assumes: slave front end decodes bytes and stretches the clock while busy is high
// Notes:   nonvolatile store is outside, one-cycle read latency
// Operation
// RQ1: a command is a write of its code to the command register at address 30h.
// RQ2: code 01h copies the live configuration into the stored power-up defaults.
// RQ3: code 02h writes the factory set into the stored defaults and leaves live settings alone.
// RQ4: code 03h takes a 147-byte block that becomes the stored defaults without touching live ones.
// RQ5: the check byte of a written block is the XOR of its 146 data bytes, verified here.
// RQ6: a stored-defaults block with a bad check or cut short is NAKed and the store is untouched; a cut block only sets blkErr, no NAK.
// RQ7: a live block with a bad check or cut short is NAKed and discarded entirely; a cut block only sets blkErr, no NAK.
// RQ8: a live block that passes is applied to all settings in one cycle.
// RQ9: the master sends the code, 146 data bytes in offset order, then the check byte.
// RQ10: after code 04h the stored defaults are returned as 146 bytes and a check byte.
// RQ11: after code 06h the live configuration is returned in the same layout plus a check byte.
// RQ12: code 07h reloads every setting from the stored defaults, as at power-up.
// RQ13: the block starts with eight-byte groups of outputs, masks, PWM selects, inversions, directions.
// RQ14: drive-mode bytes follow from 28h, seven per port in the fixed mode order.
// RQ15: three PWM bytes per PWM from 60h, divider at 90h and enable at 91h.
// RQ16: returned check bytes are the XOR of the 146 data bytes actually sent.
`timescale 1ns/10ps
`default_nettype none

module cbce_engine (
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire logic                       cmdValid,
    input  wire logic [7:0]                 cmdAddr,
    input  wire logic [7:0]                 cmdData,
    input  wire logic                       dataValid,
    input  wire logic [7:0]                 dataByte,
    input  wire logic                       xferEnd,
    output logic                            ackValid,
    output logic                            ackNak,
    input  wire logic                       rdReq,
    output logic                            rdValid,
    output logic [7:0]                      rdData,
    output logic                            busy,
    output logic                            blkErr,
    output logic                            userLoaded,
    output logic                            nvmRe,
    output logic                            nvmWe,
    output logic [7:0]                      nvmAddr,
    output logic [7:0]                      nvmWrData,
    input  wire logic [7:0]                 nvmRdData,
    output logic [cbce_pkg::CFG_W-1:0]      liveCfg
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    // sync release avoids a split reset
    logic [1:0] rstSync_q;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rst_n = rstSync_q[1];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    cbce_pkg::cbce_state_t      state_q;
    logic [7:0]                 mode_q;
    logic [7:0]                 idx_q;
    logic [7:0]                 capIdx_q;
    logic                       pend_q;
    logic [7:0]                 chk_q;
    logic                       ackValid_q;
    logic                       ackNak_q;
    logic                       rdValid_q;
    logic [7:0]                 rdData_q;
    logic                       idleRd_q;
    logic                       blkErr_q;
    logic                       userLoaded_q;
    logic [cbce_pkg::CFG_W-1:0] live_q;
    logic [7:0]                 stage [0:cbce_pkg::CFG_BYTES-1];

    function automatic logic [7:0] cbce_pick(input logic [cbce_pkg::CFG_W-1:0] v,
                                             input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        if (i < cbce_pkg::CHK_OFS) begin
            b = v[i*8 +: 8];
        end
        return b;
    endfunction : cbce_pick

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire        inIdle    = (state_q == cbce_pkg::ST_IDLE);
    wire        inRecv    = (state_q == cbce_pkg::ST_RECV);
    wire        inSend    = (state_q == cbce_pkg::ST_SEND);
    wire        inLoad    = (state_q == cbce_pkg::ST_LOAD);
    wire        inStore   = (state_q == cbce_pkg::ST_STORE);
    wire        inCommit  = (state_q == cbce_pkg::ST_COMMIT);
    // commands during store, commit or load are dropped; the front end stretches instead
    wire        cmdHit    = cmdValid && (cmdAddr == cbce_pkg::CMD_REG_ADDR)
                            && (inIdle || inRecv || inSend); // RQ1
    wire        atChk     = (idx_q == cbce_pkg::CHK_OFS);
    wire        dataByteOk = dataValid && inRecv && !atChk;
    wire        chkByte   = dataValid && inRecv && atChk;
    wire        chkPass   = (dataByte == chk_q); // RQ5
    wire        cutShort  = inRecv && (xferEnd || cmdHit); // RQ6 RQ7
    wire        fromNvm   = (mode_q == cbce_pkg::CMD_RD_NVM);
    // one read in flight at a time
    wire        sendReq   = rdReq && inSend && (idx_q < cbce_pkg::BLK_END);
    wire        loadIssue = inLoad && (idx_q < cbce_pkg::BLK_END);
    wire        loadLast  = inLoad && pend_q && (capIdx_q == cbce_pkg::CHK_OFS);
    wire        loadPass  = (nvmRdData == chk_q);
    wire        sendLast  = inSend && pend_q && (capIdx_q == cbce_pkg::CHK_OFS);
    wire [7:0]  storeByte = (mode_q == cbce_pkg::CMD_STORE)
                            ? cbce_pick(live_q, idx_q) // RQ2
                            : cbce_pick(cbce_pkg::FACTORY_CFG, idx_q); // RQ3
    wire [7:0]  sendByte  = fromNvm ? nvmRdData : cbce_pick(live_q, capIdx_q);
    wire        applyLive = chkByte && chkPass && (mode_q == cbce_pkg::CMD_WR_LIVE);

    // ---------------------------------------------------------------
    // nonvolatile store access
    // ---------------------------------------------------------------
    // store reads land one cycle late
    assign nvmAddr   = idx_q;
    assign nvmRe     = loadIssue || (sendReq && fromNvm); // RQ10 RQ12
    assign nvmWe     = inStore || inCommit; // RQ2 RQ3 RQ4
    assign nvmWrData = atChk ? chk_q
                             : (inCommit ? stage[idx_q] : storeByte);

    // ---------------------------------------------------------------
    // staging buffer
    // ---------------------------------------------------------------
    // nothing reaches the store or the live set until the check byte agrees
    always_ff @(posedge sys_clk) begin
        if (dataByteOk) begin
            stage[idx_q] <= dataByte; // RQ4 RQ9 RQ13
        end else if (inLoad && pend_q && (capIdx_q < cbce_pkg::CHK_OFS)) begin
            stage[capIdx_q] <= nvmRdData; // RQ12
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // a command restarts any open block
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= cbce_pkg::ST_LOAD;
            mode_q   <= cbce_pkg::CMD_RELOAD;
            idx_q    <= 8'h00;
            capIdx_q <= 8'h00;
            pend_q   <= 1'b0;
            chk_q    <= 8'h00;
        end else begin
            pend_q <= 1'b0;
            case (state_q)
                cbce_pkg::ST_IDLE, cbce_pkg::ST_RECV, cbce_pkg::ST_SEND: begin
                    if (cmdHit) begin
                        idx_q  <= 8'h00;
                        chk_q  <= 8'h00;
                        mode_q <= cmdData;
                        case (cmdData)
                            cbce_pkg::CMD_STORE, cbce_pkg::CMD_FACTORY: begin
                                state_q <= cbce_pkg::ST_STORE;
                            end
                            cbce_pkg::CMD_WR_NVM, cbce_pkg::CMD_WR_LIVE: begin
                                state_q <= cbce_pkg::ST_RECV;
                            end
                            cbce_pkg::CMD_RD_NVM, cbce_pkg::CMD_RD_LIVE: begin
                                state_q <= cbce_pkg::ST_SEND; // RQ10 RQ11
                            end
                            cbce_pkg::CMD_RELOAD: begin
                                state_q <= cbce_pkg::ST_LOAD; // RQ12
                            end
                            default: begin
                                state_q <= cbce_pkg::ST_IDLE;
                            end
                        endcase
                    end else if (cutShort) begin
                        state_q <= cbce_pkg::ST_IDLE; // RQ6 RQ7
                    end else if (dataByteOk) begin
                        idx_q <= idx_q + 8'h01;
                        chk_q <= chk_q ^ dataByte; // RQ5
                    end else if (chkByte) begin
                        idx_q   <= 8'h00;
                        state_q <= (chkPass && mode_q == cbce_pkg::CMD_WR_NVM)
                                   ? cbce_pkg::ST_COMMIT : cbce_pkg::ST_IDLE; // RQ4 RQ6
                    end else if (sendReq) begin
                        pend_q   <= 1'b1;
                        capIdx_q <= idx_q;
                        idx_q    <= idx_q + 8'h01;
                    end else if (pend_q && inSend) begin
                        if (capIdx_q < cbce_pkg::CHK_OFS) begin
                            chk_q <= chk_q ^ sendByte; // RQ16
                        end
                        if (sendLast) begin
                            state_q <= cbce_pkg::ST_IDLE;
                        end
                    end
                end
                cbce_pkg::ST_STORE, cbce_pkg::ST_COMMIT: begin
                    idx_q <= idx_q + 8'h01;
                    if (inStore && !atChk) begin
                        chk_q <= chk_q ^ storeByte; // RQ2 RQ3
                    end
                    if (atChk) begin
                        state_q <= cbce_pkg::ST_IDLE;
                    end
                end
                cbce_pkg::ST_LOAD: begin
                    if (loadIssue) begin
                        pend_q   <= 1'b1;
                        capIdx_q <= idx_q;
                        idx_q    <= idx_q + 8'h01;
                    end
                    if (pend_q && !loadLast) begin
                        chk_q <= chk_q ^ nvmRdData;
                    end
                    if (loadLast) begin
                        state_q <= cbce_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= cbce_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // live configuration
    // ---------------------------------------------------------------
    // a corrupt stored set falls back to factory values, as at power-up
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q       <= cbce_pkg::FACTORY_CFG;
            userLoaded_q <= 1'b0;
        end else if (applyLive || (loadLast && loadPass)) begin
            for (int i = 0; i < cbce_pkg::CFG_BYTES; i++) begin
                live_q[i*8 +: 8] <= stage[i]; // RQ8 RQ12
            end
            userLoaded_q <= loadLast ? 1'b1 : userLoaded_q;
        end else if (loadLast) begin
            live_q       <= cbce_pkg::FACTORY_CFG; // RQ12
            userLoaded_q <= 1'b0;
        end
    end
    assign liveCfg = live_q; // RQ13 RQ14 RQ15

    // ---------------------------------------------------------------
    // answers to the front end
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackValid_q <= 1'b0;
            ackNak_q   <= 1'b0;
            rdValid_q  <= 1'b0;
            rdData_q   <= 8'h00;
            idleRd_q   <= 1'b0;
            blkErr_q   <= 1'b0;
        end else begin
            ackValid_q <= dataValid;
            // bytes outside a block, or a bad check byte, are refused
            ackNak_q   <= dataValid && !dataByteOk && !(chkByte && chkPass); // RQ6 RQ7
            // idle reads keep the two-cycle beat
            idleRd_q   <= rdReq && !inSend;
            rdValid_q  <= (pend_q && inSend) || idleRd_q;
            if (pend_q && inSend) begin
                rdData_q <= sendLast ? chk_q : sendByte; // RQ10 RQ11 RQ16
            end else if (idleRd_q) begin
                rdData_q <= cbce_pkg::RD_IDLE_BYTE;
            end
            // a cut block sets blkErr, no NAK
            if (cmdHit && !inRecv) begin
                blkErr_q <= 1'b0;
            end else if (cutShort || (chkByte && !chkPass)) begin
                blkErr_q <= 1'b1; // RQ6 RQ7
            end else if (chkByte) begin
                blkErr_q <= 1'b0;
            end
        end
    end

    assign ackValid   = ackValid_q;
    assign ackNak     = ackNak_q;
    assign rdValid    = rdValid_q;
    assign rdData     = rdData_q;
    assign blkErr     = blkErr_q;
    assign userLoaded = userLoaded_q;
    // busy lets the front end stretch
    assign busy       = inLoad || inStore || inCommit;

endmodule : cbce_engine

`default_nettype wire

/* File: include/cbce_pkg.sv */
// Purpose: constants, block layout and state codes of the configuration block command engine
// Assumes: 146 data bytes plus one check byte per block
// Notes:   factory defaults are built once as a flat vector, byte 0 in the low bits
`default_nettype none

package cbce_pkg;

    // ---------------------------------------------------------------
    // block geometry
    // ---------------------------------------------------------------
    localparam int         CFG_BYTES    = 146;
    localparam int         CFG_W        = CFG_BYTES * 8;
    localparam logic [7:0] CHK_OFS      = 8'h92;
    localparam logic [7:0] BLK_END      = 8'h93;

    // ---------------------------------------------------------------
    // command register and codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_REG_ADDR = 8'h30;
    localparam logic [7:0] CMD_STORE    = 8'h01;
    localparam logic [7:0] CMD_FACTORY  = 8'h02;
    localparam logic [7:0] CMD_WR_NVM   = 8'h03;
    localparam logic [7:0] CMD_RD_NVM   = 8'h04;
    localparam logic [7:0] CMD_WR_LIVE  = 8'h05;
    localparam logic [7:0] CMD_RD_LIVE  = 8'h06;
    localparam logic [7:0] CMD_RELOAD   = 8'h07;

    // ---------------------------------------------------------------
    // block offsets
    // ---------------------------------------------------------------
    localparam int         OFS_OUT      = 'h00;
    localparam int         OFS_IMASK    = 'h08;
    localparam int         OFS_PWMSEL   = 'h10;
    localparam int         OFS_INV      = 'h18;
    localparam int         OFS_DIR      = 'h20;
    localparam int         OFS_DRV      = 'h28;
    localparam int         DRV_PER_PORT = 7;
    localparam int         OFS_PWM      = 'h60;
    localparam int         PWM_BYTES    = 3;
    localparam int         OFS_DIV      = 'h90;
    localparam int         OFS_EN       = 'h91;
    localparam int         PORTS        = 8;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_PULLUP   = 8'hFF;
    localparam logic [7:0] RST_DIV      = 8'hFF;
    localparam logic [7:0] RST_OTHER    = 8'h00;
    localparam logic [7:0] RD_IDLE_BYTE = 8'hFF;

    // pull-up is the first drive mode of each port group
    function automatic logic [CFG_W-1:0] cbce_factory();
        logic [CFG_W-1:0] v;
        v = '0;
        for (int i = 0; i < CFG_BYTES; i++) begin
            v[i*8 +: 8] = RST_OTHER;
        end
        for (int p = 0; p < PORTS; p++) begin
            v[(OFS_DRV + p*DRV_PER_PORT)*8 +: 8] = RST_PULLUP; // RQ14
        end
        v[OFS_DIV*8 +: 8] = RST_DIV; // RQ15
        return v;
    endfunction : cbce_factory

    localparam logic [CFG_W-1:0] FACTORY_CFG = cbce_factory();

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_LOAD   = 6'h02,
        ST_STORE  = 6'h04,
        ST_RECV   = 6'h08,
        ST_COMMIT = 6'h10,
        ST_SEND   = 6'h20
    } cbce_state_t;

endpackage : cbce_pkg

`default_nettype wire

/* File: dv/cbce_monitor.sv */
// Purpose: port-level checks of the configuration block command engine
// Assumes: sees only the engine's ports, one clock domain
// Notes:   bound from the testbench top file
`timescale 1ns/10ps
`default_nettype none

module cbce_monitor (
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    input wire logic                  cmdValid,
    input wire logic [7:0]            cmdAddr,
    input wire logic [7:0]            cmdData,
    input wire logic                  dataValid,
    input wire logic [7:0]            dataByte,
    input wire logic                  xferEnd,
    input wire logic                  ackValid,
    input wire logic                  ackNak,
    input wire logic                  rdReq,
    input wire logic                  rdValid,
    input wire logic [7:0]            rdData,
    input wire logic                  busy,
    input wire logic                  blkErr,
    input wire logic                  userLoaded,
    input wire logic                  nvmRe,
    input wire logic                  nvmWe,
    input wire logic [7:0]            nvmAddr,
    input wire logic [7:0]            nvmWrData,
    input wire logic [7:0]            nvmRdData,
    input wire logic [cbce_pkg::CFG_W-1:0] liveCfg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence sCmd(logic [7:0] code);
        cmdValid && cmdAddr == cbce_pkg::CMD_REG_ADDR && cmdData == code && !busy;
    endsequence
    sequence sWriteStart;
        busy && nvmWe && nvmAddr == 8'h00;
    endsequence

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_STORE_START: assert property (sCmd(cbce_pkg::CMD_STORE) |=> sWriteStart)
        else $error("store command did not start a write burst");
    AST_FACTORY_START: assert property (sCmd(cbce_pkg::CMD_FACTORY) |=> sWriteStart)
        else $error("factory command did not start a write burst");
    AST_RELOAD_START: assert property (sCmd(cbce_pkg::CMD_RELOAD) |=> busy ##[0:2] nvmRe)
        else $error("reload command did not read the store");
    AST_WR_STEP: assert property (nvmWe && $past(nvmWe) |-> nvmAddr == $past(nvmAddr) + 8'h01)
        else $error("store write address did not step by one");
    AST_WR_BUSY: assert property (nvmWe |-> busy)
        else $error("store written while not busy");
    AST_ACK_LAT: assert property (dataValid |=> ackValid)
        else $error("block byte not answered next cycle");
    AST_ACK_CAUSE: assert property (ackValid |-> $past(dataValid))
        else $error("answer without a block byte");
    AST_RD_LAT: assert property (rdReq |-> ##2 rdValid)
        else $error("read byte not returned two cycles later");
    AST_NAK_NOWRITE: assert property (ackValid && ackNak |-> (!nvmWe) [*8])
        else $error("store written after a refused block");
    AST_LIVE_HOLD: assert property ($changed(liveCfg) |-> busy || $past(busy) || (ackValid && !ackNak))
        else $error("live settings changed without cause");
endmodule : cbce_monitor

`default_nettype wire

/* File: dv/cbce_nvm_model.sv */
// Purpose: nonvolatile store beside the engine, one-cycle read latency
// Assumes: addresses 0..146, byte 146 is the check byte
// Notes:   holds a valid block at start so power-up takes the stored set
`timescale 1ns/10ps
`default_nettype none

module cbce_nvm_model (
    input  wire logic       sys_clk,
    input  wire logic       nvmRe,
    input  wire logic       nvmWe,
    input  wire logic [7:0] nvmAddr,
    input  wire logic [7:0] nvmWrData,
    output logic [7:0]      nvmRdData
);
    logic [7:0] mem [147];
    logic [7:0] acc;

    initial begin
        acc = 8'h00;
        for (int i = 0; i < 146; i++) begin
            mem[i] = 8'(i * 5 + 1);
            acc ^= mem[i];
        end
        mem[146] = acc;
        nvmRdData = 8'h5A;
    end

    // stale read data toggles so a late sample never matches by luck
    always @(posedge sys_clk) begin
        if (nvmWe)
            mem[nvmAddr] <= nvmWrData;
        nvmRdData <= nvmRe ? mem[nvmAddr] : ~nvmRdData;
    end
endmodule : cbce_nvm_model

`default_nettype wire

/* File: dv/cbce_engine_tb_top.sv */
// Purpose: self-checking bench of the configuration block command engine
// Assumes: inputs move 1 ns after the rising edge
// Notes:   store and live images are mirrored here and compared at every result
`timescale 1ns/10ps
`default_nettype none

module cbce_engine_tb_top;
    logic sys_clk = 1'b0, arst_n = 1'b0, cmdValid = 1'b0, dataValid = 1'b0;
    logic xferEnd = 1'b0, rdReq = 1'b0;
    logic [7:0] cmdAddr = 8'h00, cmdData = 8'h00, dataByte = 8'h00;
    logic ackValid, ackNak, rdValid, busy, blkErr, userLoaded, nvmRe, nvmWe;
    logic [7:0] rdData, nvmAddr, nvmWrData, nvmRdData;
    logic [cbce_pkg::CFG_W-1:0] liveCfg;
    logic [7:0] nvmExp [147];
    logic [7:0] liveExp [146];
    logic [7:0] blk [146];
    int errors = 0;
    int cmp_count = 0;

    always #20 sys_clk = ~sys_clk;

    cbce_engine cbce_engine_i (.sys_clk(sys_clk), .arst_n(arst_n), .cmdValid(cmdValid),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .dataValid(dataValid), .dataByte(dataByte),
        .xferEnd(xferEnd), .ackValid(ackValid), .ackNak(ackNak), .rdReq(rdReq),
        .rdValid(rdValid), .rdData(rdData), .busy(busy), .blkErr(blkErr),
        .userLoaded(userLoaded), .nvmRe(nvmRe), .nvmWe(nvmWe), .nvmAddr(nvmAddr),
        .nvmWrData(nvmWrData), .nvmRdData(nvmRdData), .liveCfg(liveCfg));
    cbce_nvm_model cbce_nvm_model_i (.sys_clk(sys_clk), .nvmRe(nvmRe), .nvmWe(nvmWe),
        .nvmAddr(nvmAddr), .nvmWrData(nvmWrData), .nvmRdData(nvmRdData));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic cmd(input logic [7:0] addr, input logic [7:0] code);
        cmdValid = 1'b1;
        cmdAddr = addr;
        cmdData = code;
        tick;
        cmdValid = 1'b0;
        tick;
    endtask : cmd

    task automatic waitIdle;
        int n;
        n = 0;
        tick;
        while (busy !== 1'b0 && n < 400) begin
            tick;
            n++;
        end
        chk("busy", {7'h00, busy}, 8'h00);
    endtask : waitIdle

    task automatic wrByte(input logic [7:0] b, input logic nak);
        dataValid = 1'b1;
        dataByte = b;
        tick;
        chk("ackValid", {7'h00, ackValid}, 8'h01);
        chk("ackNak", {7'h00, ackNak}, {7'h00, nak});
    endtask : wrByte

    // short blocks end with the stop pulse before the check byte
    task automatic wrBlk(input logic [7:0] code, input int n, input logic [7:0] flip);
        logic [7:0] x;
        x = 8'h00;
        cmd(8'h30, code);
        for (int i = 0; i < n; i++) begin
            blk[i] = 8'($urandom);
            x ^= blk[i];
            wrByte(blk[i], 1'b0);
        end
        if (n == 146)
            wrByte(x ^ flip, flip != 8'h00);
        dataValid = 1'b0;
        xferEnd = 1'b1;
        tick;
        xferEnd = 1'b0;
    endtask : wrBlk

    task automatic rdBlk(input logic [7:0] code);
        logic [7:0] x;
        logic [7:0] b;
        x = 8'h00;
        cmd(8'h30, code);
        for (int i = 0; i < 147; i++) begin
            rdReq = 1'b1;
            tick;
            rdReq = 1'b0;
            tick;
            b = (i == 146) ? x : (code == 8'h04) ? nvmExp[i] : liveExp[i];
            chk("rdValid", {7'h00, rdValid}, 8'h01);
            chk("rdData", rdData, b);
            x ^= b;
        end
    endtask : rdBlk

    task automatic chkLive;
        for (int i = 0; i < 146; i++)
            chk("liveCfg", liveCfg[i*8 +: 8], liveExp[i]);
    endtask : chkLive

    task automatic fixChk;
        nvmExp[146] = 8'h00;
        for (int i = 0; i < 146; i++)
            nvmExp[146] ^= nvmExp[i];
    endtask : fixChk

    // ---------------------------------------------------------------
    // sequence of tests
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(62));
        for (int i = 0; i < 146; i++)
            nvmExp[i] = 8'(i * 5 + 1);
        fixChk;
        liveExp = nvmExp[0:145];
        repeat (20) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        waitIdle;
        chk("userLoaded", {7'h00, userLoaded}, 8'h01);
        chkLive;
        $display("test power-up load done");
        rdReq = 1'b1;
        tick;
        rdReq = 1'b0;
        tick;
        chk("rdData", rdData, cbce_pkg::RD_IDLE_BYTE);
        rdBlk(8'h04);
        $display("test stored read done");
        wrBlk(8'h05, 146, 8'h00);
        liveExp = blk;
        chkLive;
        chk("blkErr", {7'h00, blkErr}, 8'h00);
        rdBlk(8'h06);
        $display("test live write and read done");
        wrBlk(8'h05, 146, 8'h01);
        chk("blkErr", {7'h00, blkErr}, 8'h01);
        chkLive;
        $display("test bad live block done");
        wrBlk(8'h03, 10, 8'h00);
        waitIdle;
        chk("blkErr", {7'h00, blkErr}, 8'h01);
        rdBlk(8'h04);
        $display("test short stored block done");
        wrBlk(8'h03, 146, 8'h00);
        waitIdle;
        nvmExp[0:145] = blk;
        fixChk;
        chkLive;
        rdBlk(8'h04);
        $display("test stored write done");
        cmd(8'h31, 8'h07);
        chk("busy", {7'h00, busy}, 8'h00);
        cmd(8'h30, 8'h01);
        waitIdle;
        nvmExp[0:145] = liveExp;
        fixChk;
        rdBlk(8'h04);
        $display("test store live done");
        cmd(8'h30, 8'h02);
        waitIdle;
        for (int i = 0; i < 146; i++)
            nvmExp[i] = (i == 8'h90 || (i >= 8'h28 && i < 8'h60 && (i - 8'h28) % 7 == 0))
                        ? 8'hFF : 8'h00;
        fixChk;
        chkLive;
        rdBlk(8'h04);
        $display("test factory restore done");
        cmd(8'h30, 8'h07);
        waitIdle;
        liveExp = nvmExp[0:145];
        chkLive;
        $display("test reload done");
        end_sim;
    end

    // whole run needs about 3000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        $display("unexpected watchdog: expected end of tests, seen timeout");
        end_sim;
    end
endmodule : cbce_engine_tb_top

bind cbce_engine cbce_monitor cbce_monitor_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdData(cmdData), .dataValid(dataValid),
    .dataByte(dataByte), .xferEnd(xferEnd), .ackValid(ackValid), .ackNak(ackNak),
    .rdReq(rdReq), .rdValid(rdValid), .rdData(rdData), .busy(busy), .blkErr(blkErr),
    .userLoaded(userLoaded), .nvmRe(nvmRe), .nvmWe(nvmWe), .nvmAddr(nvmAddr),
    .nvmWrData(nvmWrData), .nvmRdData(nvmRdData), .liveCfg(liveCfg));

`default_nettype wire
